// file: verilog/timer_b_routing_pkg.sv
// package: constants and carrier types for the timer routing block
package timer_b_routing_pkg;

  // ********************************
  // timer clock source codes
  // ********************************
  localparam logic [1:0] CLK_SEL_EXT   = 2'h0;  // external timer clock pin
  localparam logic [1:0] CLK_SEL_ACLK  = 2'h1;  // auxiliary clock
  localparam logic [1:0] CLK_SEL_SMCLK = 2'h2;  // sub-main clock
  localparam logic [1:0] CLK_SEL_TOUCH = 2'h3;  // touch I/O clock

  // ********************************
  // capture input select codes
  // ********************************
  localparam logic [1:0] CAP_SEL_A   = 2'h0;  // input a
  localparam logic [1:0] CAP_SEL_B   = 2'h1;  // input b
  localparam logic [1:0] CAP_SEL_GND = 2'h2;  // ground
  localparam logic [1:0] CAP_SEL_VCC = 2'h3;  // supply

  // ********************************
  // counter modes
  // ********************************
  localparam logic [1:0] MODE_STOP = 2'h0;  // halted
  localparam logic [1:0] MODE_UP   = 2'h1;  // wraps at channel 0 value
  localparam logic [1:0] MODE_CONT = 2'h2;  // wraps at full scale
  localparam logic [1:0] MODE_RSVD = 2'h3;  // treated as continuous

  // ********************************
  // reset values
  // ********************************
  localparam logic [15:0] COUNT_RESET = 16'h0000;  // counter after reset
  localparam logic [15:0] CCR_RESET   = 16'h0000;  // channel value after reset
  localparam int          NUM_CHAN    = 3;         // channel count

  // per-channel configuration
  typedef struct packed {
    logic       capture_mode;  // 1 capture, 0 compare
    logic [1:0] cap_edge;      // bit0 rising, bit1 falling
    logic [1:0] cap_sel;       // capture input select
    logic       out_set_reset; // 1 set/reset pwm, 0 toggle
  } chan_cfg_t;

  // infrared modulation controls
  typedef struct packed {
    logic ir_enable;              // modulation on
    logic ir_polarity_select;     // invert result
    logic ir_mode_select;         // 0 ask, 1 fsk
    logic ir_data_source_select;  // 0 serial data, 1 software value
    logic ir_data_value;          // software data bit
  } ir_cfg_t;

endpackage

// file: verilog/timer_b_signal_routing.sv
// module: timer with three channels and its pin, trigger and infrared routing
// Operation
// - one 16-bit up counter, three channels
// - capture, compare, pwm and interval timing
// - overflow flag plus one flag per channel
// - channel 0 no pin, sets up-mode wrap
// - remap bit picks capture pin group
// - pwm drives both groups, per-pin select
// - trigger forces all timer pads high-z
// - trigger source: comparator or pin
// - timer modulates serial transmit pin
// - ir enable, polarity, mode, source, data
// - rtc overflow feeds channel 0 input a
`timescale 1ns/1ps
module timer_b_signal_routing #(
  parameter int CNT_W = 16  // counter width
) (
  input  wire logic                                  sys_clk_i,             // system clock
  input  wire logic                                  arst_n_i,              // async reset, low
  input  wire logic [1:0]                            clk_sel_i,             // timer clock source
  input  wire logic                                  timer_ext_clock_i,     // external clock pin
  input  wire logic                                  aclk_i,                // aux clock level
  input  wire logic                                  smclk_i,               // sub-main clock level
  input  wire logic                                  touch_clock_in_i,      // touch I/O clock
  input  wire logic [1:0]                            mode_i,                // counter mode
  input  wire logic                                  count_clear_i,         // clear counter pulse
  input  wire timer_b_routing_pkg::chan_cfg_t [2:0]  chan_cfg_i,            // channel configs
  input  wire logic [2:0][CNT_W-1:0]                 compare_value_i,       // compare load values
  input  wire logic [2:0]                            compare_load_i,        // load strobes
  input  wire logic [2:0]                            flag_clear_i,          // channel flag clears
  input  wire logic                                  ovf_flag_clear_i,      // overflow flag clear
  input  wire logic                                  rtc_overflow_i,        // rtc overflow pulse
  input  wire logic                                  comparator_out_i,      // comparator output
  input  wire logic                                  touch_capture_i,       // touch capture source
  input  wire logic                                  capture_pin_remap_i,   // pin group select
  input  wire logic [1:0]                            group0_pin_i,          // group 0 pin levels
  input  wire logic [1:0]                            group1_pin_i,          // group 1 pin levels
  input  wire logic [1:0]                            group0_function_select_i, // group 0 pin selects
  input  wire logic [1:0]                            group1_function_select_i, // group 1 pin selects
  input  wire logic                                  hiz_trigger_select_i,  // 0 comparator, 1 pin
  input  wire logic                                  hiz_trigger_pin_i,     // external trigger pin
  input  wire timer_b_routing_pkg::ir_cfg_t          ir_cfg_i,              // infrared controls
  input  wire logic                                  uart_tx_data_i,        // serial transmit data
  output logic [CNT_W-1:0]                           count_o,               // counter value
  output logic [2:0][CNT_W-1:0]                      ccr_o,                 // channel registers
  output logic [2:0]                                 chan_flag_o,           // channel flags
  output logic                                       ovf_flag_o,            // overflow flag
  output logic [2:0]                                 timer_out_o,           // channel outputs
  output logic [1:0]                                 group0_pin_o,          // group 0 pad data
  output logic [1:0]                                 group0_pin_oe_n_o,     // group 0 enable, low
  output logic [1:0]                                 group1_pin_o,          // group 1 pad data
  output logic [1:0]                                 group1_pin_oe_n_o,     // group 1 enable, low
  output logic                                       output_hiz_trigger_o,  // trigger active
  output logic                                       uart_transmit_pin_o    // modulated tx pin
);

  // width guard: wrap and compare logic are sized for a 16-bit counter
  if (CNT_W != 16) begin : g_width_check
    $error("counter width must be 16");
  end

  // ********************************
  // clock source and edge detect
  // ********************************
  logic tclk_mux;  // selected clock level
  logic tclk_q;    // previous level
  logic tick;      // rising edge of timer clock
  assign tclk_mux = (clk_sel_i == timer_b_routing_pkg::CLK_SEL_EXT)  ? timer_ext_clock_i :
                    (clk_sel_i == timer_b_routing_pkg::CLK_SEL_ACLK) ? aclk_i :
                    (clk_sel_i == timer_b_routing_pkg::CLK_SEL_SMCLK)? smclk_i : touch_clock_in_i;
  assign tick = tclk_mux & ~tclk_q;

  // a source that sits high at reset release yields one early tick
  // edge history
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tclk_q <= 1'b0;
    end else begin
      tclk_q <= tclk_mux;
    end
  end

  // ********************************
  // counter
  // ********************************
  logic [CNT_W-1:0] count_q;   // counter
  logic [CNT_W-1:0] count_d;   // next counter
  logic             wrap;      // counter wraps this tick
  logic             run;       // mode runs
  logic             up_mode;   // up mode active
  assign run     = (mode_i != timer_b_routing_pkg::MODE_STOP);
  assign up_mode = (mode_i == timer_b_routing_pkg::MODE_UP);
  assign wrap    = tick & run & (up_mode ? (count_q >= ccr_o[0]) : (&count_q));
  // clear outranks wrap and count; wrap and match events still fire
  assign count_d = count_clear_i ? timer_b_routing_pkg::COUNT_RESET :
                   wrap          ? timer_b_routing_pkg::COUNT_RESET :
                   (tick & run)  ? count_q + CNT_W'(1) : count_q;

  // counter register
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_q <= timer_b_routing_pkg::COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end
  assign count_o = count_q;

  // overflow flag, set wins over clear
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovf_flag_o <= 1'b0;
    end else begin
      ovf_flag_o <= wrap | (ovf_flag_o & ~ovf_flag_clear_i);
    end
  end

  // ********************************
  // capture input routing
  // ********************************
  logic [2:0] in_a;    // capture input a per channel
  logic [2:0] in_b;    // capture input b per channel
  logic [1:0] pin_in;  // selected pin group levels
  assign pin_in = capture_pin_remap_i ? group1_pin_i : group0_pin_i;
  assign in_a   = {pin_in[1], pin_in[0], rtc_overflow_i};
  assign in_b   = {touch_capture_i, comparator_out_i, aclk_i};

  // ********************************
  // channels
  // ********************************
  // limitation: vcc selected in capture mode captures once after reset
  genvar ch;
  generate
    for (ch = 0; ch < timer_b_routing_pkg::NUM_CHAN; ch++) begin : g_chan
      logic             cci;     // selected capture signal
      logic             cci_q;   // previous capture signal
      logic             cap_ev;  // capture edge event
      logic             cmp_ev;  // compare match event
      logic             ev;      // flag event
      logic [CNT_W-1:0] ccr_q;   // capture/compare register
      logic             out_q;   // output latch
      assign cci = (chan_cfg_i[ch].cap_sel == timer_b_routing_pkg::CAP_SEL_A) ? in_a[ch] :
                   (chan_cfg_i[ch].cap_sel == timer_b_routing_pkg::CAP_SEL_B) ? in_b[ch] :
                   (chan_cfg_i[ch].cap_sel == timer_b_routing_pkg::CAP_SEL_GND) ? 1'b0 : 1'b1;
      assign cap_ev = chan_cfg_i[ch].capture_mode &
                      ((chan_cfg_i[ch].cap_edge[0] & cci & ~cci_q) |
                       (chan_cfg_i[ch].cap_edge[1] & ~cci & cci_q));
      assign cmp_ev = ~chan_cfg_i[ch].capture_mode & tick & run & (count_q == ccr_q);
      assign ev     = cap_ev | cmp_ev;

      // capture history, register and output
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          cci_q <= 1'b0;
          ccr_q <= timer_b_routing_pkg::CCR_RESET;
          out_q <= 1'b0;
        end else begin
          cci_q <= cci;
          if (cap_ev) begin
            ccr_q <= count_q;  // capture snapshot
          end else if (compare_load_i[ch]) begin
            ccr_q <= compare_value_i[ch];
          end
          if (cmp_ev) begin
            out_q <= chan_cfg_i[ch].out_set_reset ? 1'b0 : ~out_q;
          end else if (wrap && chan_cfg_i[ch].out_set_reset) begin
            out_q <= 1'b1;  // pwm period start
          end
        end
      end

      // channel flag, set wins over clear
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          chan_flag_o[ch] <= 1'b0;
        end else begin
          chan_flag_o[ch] <= ev | (chan_flag_o[ch] & ~flag_clear_i[ch]);
        end
      end
      assign ccr_o[ch]       = ccr_q;
      assign timer_out_o[ch] = out_q;
    end
  endgenerate

  // ********************************
  // high impedance trigger
  // ********************************
  // level trigger: pads float for as long as the source stands
  assign output_hiz_trigger_o = hiz_trigger_select_i ? hiz_trigger_pin_i : comparator_out_i;

  // ********************************
  // pad outputs, channel 0 has none
  // ********************************
  // both groups carry pwm; remap only steers the capture inputs
  assign group0_pin_o      = timer_out_o[2:1];
  assign group1_pin_o      = timer_out_o[2:1];
  assign group0_pin_oe_n_o = ~(group0_function_select_i & {2{~output_hiz_trigger_o}});
  assign group1_pin_oe_n_o = ~(group1_function_select_i & {2{~output_hiz_trigger_o}});

  // ********************************
  // infrared modulation
  // ********************************
  logic ir_data;  // data bit chosen
  logic ir_mod;   // modulated value
  logic tx_d;     // next pin value
  // ask gates one carrier by data, fsk picks between two carriers
  assign ir_data = ir_cfg_i.ir_data_source_select ? ir_cfg_i.ir_data_value : uart_tx_data_i;
  assign ir_mod  = ir_cfg_i.ir_mode_select ? (ir_data ? timer_out_o[1] : timer_out_o[2])
                                           : (ir_data & timer_out_o[1]);
  assign tx_d    = ir_cfg_i.ir_enable ? (ir_mod ^ ir_cfg_i.ir_polarity_select) : uart_tx_data_i;

  // one flop keeps mux glitches off the transmit pad
  // registered transmit pin
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      uart_transmit_pin_o <= 1'b1;
    end else begin
      uart_transmit_pin_o <= tx_d;
    end
  end

endmodule

// file: test/timer_b_signal_routing_chk.sv
// checker: port-level assertions for the timer routing block
`timescale 1ns/1ps
module timer_b_signal_routing_chk #(
  parameter int CNT_W = 16  // counter width
) (
  input wire logic                                 sys_clk_i,
  input wire logic                                 arst_n_i,
  input wire logic                                 count_clear_i,
  input wire logic                                 rtc_overflow_i,
  input wire logic                                 comparator_out_i,
  input wire logic                                 hiz_trigger_select_i,
  input wire logic                                 hiz_trigger_pin_i,
  input wire logic                                 uart_tx_data_i,
  input wire logic                                 timer_ext_clock_i,
  input wire logic                                 aclk_i,
  input wire logic                                 smclk_i,
  input wire logic                                 touch_clock_in_i,
  input wire logic                                 output_hiz_trigger_o,
  input wire logic                                 uart_transmit_pin_o,
  input wire logic                                 ovf_flag_o,
  input wire logic [1:0]                           clk_sel_i,
  input wire logic [1:0]                           mode_i,
  input wire logic [1:0]                           group0_function_select_i,
  input wire logic [1:0]                           group1_function_select_i,
  input wire logic [1:0]                           group0_pin_o,
  input wire logic [1:0]                           group0_pin_oe_n_o,
  input wire logic [1:0]                           group1_pin_o,
  input wire logic [1:0]                           group1_pin_oe_n_o,
  input wire logic [2:0]                           timer_out_o,
  input wire logic [2:0]                           chan_flag_o,
  input wire logic [CNT_W-1:0]                     count_o,
  input wire logic [2:0][CNT_W-1:0]                ccr_o,
  input wire timer_b_routing_pkg::chan_cfg_t [2:0] chan_cfg_i,
  input wire timer_b_routing_pkg::ir_cfg_t         ir_cfg_i
);
  // ****************************
  // helper logic
  // ****************************
  logic prev_q;  // selected clock one cycle ago
  wire logic [3:0] srcs = {touch_clock_in_i, smclk_i, aclk_i, timer_ext_clock_i};  // sources by code
  wire logic tick = srcs[clk_sel_i] & ~prev_q;  // rising edge of selected clock
  wire logic wrap = mode_i == timer_b_routing_pkg::MODE_UP && count_o >= ccr_o[0];  // up-mode limit hit
  // edge detector of the selected clock
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) prev_q <= 1'b0;
    else prev_q <= srcs[clk_sel_i];
  end
  // transmit pin value expected from controls, data and channel outputs
  function automatic logic ir_exp(timer_b_routing_pkg::ir_cfg_t c, logic u, logic [2:0] t);
    logic d;
    d = c.ir_data_source_select ? c.ir_data_value : u;
    return c.ir_enable ? ((c.ir_mode_select ? (d ? t[1] : t[2]) : d & t[1]) ^ c.ir_polarity_select) : u;
  endfunction
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // counting tick that is not overridden by clear
  sequence s_run_tick;
    tick && mode_i != timer_b_routing_pkg::MODE_STOP && !count_clear_i;
  endsequence
  // rising rtc overflow seen by channel 0 input a
  sequence s_rtc_edge;
    chan_cfg_i[0].capture_mode && chan_cfg_i[0].cap_sel == 2'h0 && chan_cfg_i[0].cap_edge[0] && $rose(rtc_overflow_i);
  endsequence
  chk_oe_both_groups: assert property (
    {group0_pin_oe_n_o, group1_pin_oe_n_o} == (~{group0_function_select_i, group1_function_select_i} | {4{output_hiz_trigger_o}}))
    else $error("pad enable mismatch");
  chk_pin_data_both: assert property ({group0_pin_o, group1_pin_o} == {2{timer_out_o[2:1]}})
    else $error("pad data mismatch");
  chk_hiz_src_mux: assert property (
    output_hiz_trigger_o == (hiz_trigger_select_i ? hiz_trigger_pin_i : comparator_out_i))
    else $error("trigger source mismatch");
  chk_ir_tx_path: assert property (
    $past(arst_n_i) |-> uart_transmit_pin_o == ir_exp($past(ir_cfg_i), $past(uart_tx_data_i), $past(timer_out_o)))
    else $error("transmit pin mismatch");
  chk_count_step: assert property (s_run_tick ##0 !wrap |=> count_o == $past(count_o) + 1'b1)
    else $error("count step mismatch");
  chk_up_wrap: assert property (s_run_tick ##0 wrap |=> count_o == '0 && ovf_flag_o)
    else $error("up mode wrap mismatch");
  chk_stop_hold: assert property (mode_i == timer_b_routing_pkg::MODE_STOP && !count_clear_i |=> $stable(count_o))
    else $error("count moved while stopped");
  chk_rtc_capture: assert property (s_rtc_edge |=> chan_flag_o[0] && ccr_o[0] == $past(count_o))
    else $error("rtc capture mismatch");
endmodule
bind timer_b_signal_routing timer_b_signal_routing_chk #(
  .CNT_W(CNT_W)
) chk_u (
  .sys_clk_i(sys_clk_i),
  .arst_n_i(arst_n_i),
  .count_clear_i(count_clear_i),
  .rtc_overflow_i(rtc_overflow_i),
  .comparator_out_i(comparator_out_i),
  .hiz_trigger_select_i(hiz_trigger_select_i),
  .hiz_trigger_pin_i(hiz_trigger_pin_i),
  .uart_tx_data_i(uart_tx_data_i),
  .timer_ext_clock_i(timer_ext_clock_i),
  .aclk_i(aclk_i),
  .smclk_i(smclk_i),
  .touch_clock_in_i(touch_clock_in_i),
  .output_hiz_trigger_o(output_hiz_trigger_o),
  .uart_transmit_pin_o(uart_transmit_pin_o),
  .ovf_flag_o(ovf_flag_o),
  .clk_sel_i(clk_sel_i),
  .mode_i(mode_i),
  .group0_function_select_i(group0_function_select_i),
  .group1_function_select_i(group1_function_select_i),
  .group0_pin_o(group0_pin_o),
  .group0_pin_oe_n_o(group0_pin_oe_n_o),
  .group1_pin_o(group1_pin_o),
  .group1_pin_oe_n_o(group1_pin_oe_n_o),
  .timer_out_o(timer_out_o),
  .chan_flag_o(chan_flag_o),
  .count_o(count_o),
  .ccr_o(ccr_o),
  .chan_cfg_i(chan_cfg_i),
  .ir_cfg_i(ir_cfg_i)
);

// file: test/periph_src_model.sv
// partner: on-chip clock levels and rtc overflow events feeding the timer
`timescale 1ns/1ps
module periph_src_model (
  input  wire logic       sys_clk_i,  // system clock
  input  wire logic       run_i,      // sources active
  output logic [3:0]      clks_o,     // ext, aclk, smclk, touch levels
  output logic            rtc_ovf_o   // rtc overflow pulse
);
  logic [4:0] div_q = 5'h00;  // shared divider
  // moves on the falling edge, away from the sampling edge; stands at 0 when stopped
  always @(negedge sys_clk_i) div_q <= run_i ? div_q + 5'h01 : 5'h00;
  assign clks_o    = {div_q[4], div_q[3], div_q[2], div_q[1]};  // periods 4 to 32 cycles
  assign rtc_ovf_o = run_i && div_q == 5'h1F;                   // one pulse per 32 cycles
endmodule

// file: test/timer_b_signal_routing_tb.sv
// testbench: timer routing block against a cycle model
`timescale 1ns/1ps
module timer_b_signal_routing_tb;
  // ****************************
  // stimulus, outputs and model state
  // ****************************
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, clr = 1'b0, oclr = 1'b0, rmp = 1'b0;
  logic tsel = 1'b0, tpin = 1'b0, comp = 1'b0, utx = 1'b0, mo, mtx, mprev, mrtc, mcp, rtc, ovf, hiz, txo;
  logic [1:0] csel = 2'h0, mode = 2'h0, fs0 = 2'h0, fs1 = 2'h0, g0 = 2'h0, g1 = 2'h0, p0, p1, oe0, oe1;
  logic [2:0] ld = 3'h0, fclr = 3'h0, flg, tout, mout, mflg;
  logic [2:0][15:0] cval = '0, ccr;
  logic [15:0] cnt;
  logic [3:0] pclk;
  timer_b_routing_pkg::chan_cfg_t [2:0] cfg = '0;
  timer_b_routing_pkg::ir_cfg_t ir = '0;
  int m, c0, c1, c2, n_errors = 0, n_checks = 0;
  periph_src_model src_u (.sys_clk_i(clk), .run_i(run), .clks_o(pclk), .rtc_ovf_o(rtc));
  timer_b_signal_routing dut_u (.sys_clk_i(clk), .arst_n_i(rst_n), .clk_sel_i(csel), .timer_ext_clock_i(pclk[0]),
    .aclk_i(pclk[1]), .smclk_i(pclk[2]), .touch_clock_in_i(pclk[3]), .mode_i(mode), .count_clear_i(clr),
    .chan_cfg_i(cfg), .compare_value_i(cval), .compare_load_i(ld), .flag_clear_i(fclr), .ovf_flag_clear_i(oclr),
    .rtc_overflow_i(rtc), .comparator_out_i(comp), .touch_capture_i(1'b0), .capture_pin_remap_i(rmp),
    .group0_pin_i(g0), .group1_pin_i(g1), .group0_function_select_i(fs0), .group1_function_select_i(fs1),
    .hiz_trigger_select_i(tsel), .hiz_trigger_pin_i(tpin), .ir_cfg_i(ir), .uart_tx_data_i(utx), .count_o(cnt),
    .ccr_o(ccr), .chan_flag_o(flg), .ovf_flag_o(ovf), .timer_out_o(tout), .group0_pin_o(p0),
    .group0_pin_oe_n_o(oe0), .group1_pin_o(p1), .group1_pin_oe_n_o(oe1), .output_hiz_trigger_o(hiz),
    .uart_transmit_pin_o(txo));
  initial forever #25 clk = ~clk;  // 20 MHz
  // watchdog well past the expected run of about 700 cycles
  initial begin
    #100000;
    n_errors++;
    results();
  end
  // compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // print counts and verdict, then stop
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // cycle model: compares outputs before the edge lands, then steps
  always @(posedge clk or negedge rst_n) begin
    logic tk, w, d, cp, hz;
    int pm;
    if (!rst_n) begin
      {m, c0, c1, c2} = '0;
      {mo, mprev, mrtc, mcp, mout, mflg} = '0;
      mtx = 1'b1;
    end else begin
      hz = tsel ? tpin : comp;
      check(cnt, m[15:0]);
      check(ccr[0], c0[15:0]);
      check(ccr[1], c1[15:0]);
      check(ccr[2], c2[15:0]);
      check(16'({ovf, flg, tout}), 16'({mo, mflg, mout}));
      check(16'({p0, p1}), 16'({2{mout[2:1]}}));
      check(16'({oe0, oe1, hiz}), 16'({~{fs0, fs1} | {4{hz}}, hz}));
      check(16'(txo), 16'(mtx));
      tk = pclk[csel] & ~mprev;
      mprev = pclk[csel];
      d = ir.ir_data_source_select ? ir.ir_data_value : utx;
      mtx = ir.ir_enable ? ((ir.ir_mode_select ? (d ? mout[1] : mout[2]) : d & mout[1]) ^ ir.ir_polarity_select) : utx;
      cp = rmp ? g1[0] : g0[0];
      pm = m;
      mflg = mflg & ~fclr;
      if (oclr) mo = 1'b0;
      // events use the values held before this edge; a match outranks the period set
      if (tk && mode != 2'h0) begin
        w = (mode == timer_b_routing_pkg::MODE_UP) ? pm >= c0 : pm == 65535;
        for (int j = 0; j < 3; j++) begin
          if (!cfg[j].capture_mode && pm == (j == 0 ? c0 : j == 1 ? c1 : c2)) begin
            {mout[j], mflg[j]} = {cfg[j].out_set_reset ? 1'b0 : ~mout[j], 1'b1};
          end else if (w && cfg[j].out_set_reset) begin
            mout[j] = 1'b1;
          end
        end
        mo = mo | w;
        m = w ? 0 : m + 1;
      end
      if (clr) m = 0;
      if (ld[0]) c0 = cval[0];
      if (ld[1]) c1 = cval[1];
      if (ld[2]) c2 = cval[2];
      if (cfg[0].capture_mode && rtc && !mrtc) {c0, mflg[0]} = {pm, 1'b1};
      if (cfg[1].capture_mode && cp && !mcp) {c1, mflg[1]} = {pm, 1'b1};
      {mrtc, mcp} = {rtc, cp};
    end
  end
  // main sequence: inputs change on the falling edge
  initial begin
    void'($urandom(32'h40d5));
    {cfg[1].out_set_reset, cfg[2].out_set_reset, cfg[0].cap_edge, cfg[1].cap_edge} = 6'h35;
    cval = {16'h0003, 16'h0001, 16'h0002};
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    ld = 3'h7;
    @(negedge clk);
    ld = 3'h0;
    // every clock source, up, reserved and continuous modes; rtc capture in the last
    for (int s = 0; s < 4; s++) begin
      csel = s[1:0];
      mode = (s == 3) ? timer_b_routing_pkg::MODE_CONT : (s == 2) ? timer_b_routing_pkg::MODE_RSVD : 2'h1;
      cfg[0].capture_mode = (s == 3);
      run = 1'b1;
      repeat (150) @(negedge clk);
      {run, mode, clr, oclr, fclr} = {3'h0, s != 3, 1'b1, 3'h7};
      @(negedge clk);
      {clr, oclr, fclr} = 5'h00;
      @(negedge clk);
    end
    // random pad, trigger and infrared controls while stopped
    for (int i = 0; i < 40; i++) begin
      {rmp, tsel, tpin, comp, utx, fs0, fs1, ir} = 14'($urandom);
      @(negedge clk);
    end
    // capture pin groups: selected and unselected pulses, falling edge refused
    cfg[1].capture_mode = 1'b1;
    for (int r = 0; r < 2; r++) begin
      {rmp, ld, cval[1]} = {r[0], 3'h2, 16'hA5A5 ^ 16'(r)};
      @(negedge clk);
      ld = 3'h0;
      for (int k = 0; k < 4; k++) begin
        {g0[0], g1[0]} = {k == 0, k == 2};
        @(negedge clk);
      end
    end
    results();
  end
endmodule
